// ===== rtl/adcrr_top.v
// Round-robin converter channel scheduler with APB register access.
// Assumes an external converter with a start/done handshake, synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
`include "adcrr_map.vh"

module adcrr_top #(
  parameter DATA_W = 10
) (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire gate_on,
  output reg conv_start,
  output reg [2:0] conv_channel,
  input wire conv_done,
  input wire [DATA_W-1:0] conv_data,
  output wire [15:0] digital_output_config,
  output wire [15:0] adc_channel_schedule
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  // Channel codes presented to the converter; code is input number minus one, not order position
  localparam [2:0] CH_IN1 = 3'h0;
  localparam [2:0] CH_IN2 = 3'h1;
  localparam [2:0] CH_IN3 = 3'h2;
  localparam [2:0] CH_IN4 = 3'h3;
  localparam [2:0] CH_IN5 = 3'h4;
  localparam [2:0] CH_IN6 = 3'h5;
  localparam [2:0] CH_TEMP = 3'h6;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;

  // Order position to channel code: in1, in3, in5, in2, in4, in6, temp
  function [2:0] pos_to_channel;
    input [2:0] p;
    begin
      case (p)
        3'h0: pos_to_channel = CH_IN1;
        3'h1: pos_to_channel = CH_IN3;
        3'h2: pos_to_channel = CH_IN5;
        3'h3: pos_to_channel = CH_IN2;
        3'h4: pos_to_channel = CH_IN4;
        3'h5: pos_to_channel = CH_IN6;
        default: pos_to_channel = CH_TEMP;
      endcase
    end
  endfunction

  // Channel code to result slot index (slot_1 is index 0)
  function [2:0] channel_to_slot;
    input [2:0] c;
    begin
      case (c)
        CH_IN1: channel_to_slot = 3'h0;
        CH_IN3: channel_to_slot = 3'h1;
        CH_IN5: channel_to_slot = 3'h2;
        CH_IN2: channel_to_slot = 3'h3;
        CH_IN4: channel_to_slot = 3'h4;
        CH_IN6: channel_to_slot = 3'h5;
        default: channel_to_slot = 3'h6;
      endcase
    end
  endfunction

  // Byte address to result slot index; meaningful only under is_slot_addr
  function [2:0] slot_index;
    input [7:0] a;
    reg [7:0] off;
    begin
      off = a - `ADCRR_ADDR_RESULT_BASE;
      slot_index = off[`ADCRR_WORD_LSB +: 3];
    end
  endfunction

  // Slots sit in one aligned run of words; anything else reads as zero
  function is_slot_addr;
    input [7:0] a;
    begin
      is_slot_addr = (a >= `ADCRR_ADDR_RESULT_BASE) && (a <= `ADCRR_ADDR_RESULT_LAST) &&
                     (a[`ADCRR_WORD_LSB-1:0] == 2'h0);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] schedule;
  reg [15:0] dout_cfg;
  reg [DATA_W-1:0] result_slot [0:`ADCRR_NUM_SLOTS-1];
  reg [1:0] state;
  reg [2:0] cur_pos;
  reg phase_on;
  reg [31:0] rdata;

  wire wr_en;
  wire rd_en;
  wire [2:0] rd_slot;
  wire slot_hit;
  wire hit_schedule;
  wire hit_dout;
  wire hit_status;
  reg [31:0] status_word;

  // Zero wait states: every access phase completes in one cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign adc_channel_schedule = schedule;
  assign digital_output_config = dout_cfg;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign hit_schedule = (paddr == `ADCRR_ADDR_SCHEDULE);
  assign hit_dout = (paddr == `ADCRR_ADDR_DIGITAL_OUTPUT_CONFIG);
  assign hit_status = (paddr == `ADCRR_ADDR_STATUS);
  assign rd_slot = slot_index(paddr);
  assign slot_hit = is_slot_addr(paddr);

  // Read data is captured in the setup cycle so it is registered in the access cycle
  assign prdata = rdata;

  // ----------------------------------------
  // APB register writes
  // ----------------------------------------
  reg [15:0] next_schedule;
  reg [15:0] next_dout_cfg;

  always @* begin
    next_schedule = schedule;
    next_dout_cfg = dout_cfg;
    if (wr_en && hit_schedule) begin
      // Reserved bits are dropped so they always read back zero
      next_schedule = pwdata[15:0] & `ADCRR_SCHEDULE_MASK;
    end
    if (wr_en && hit_dout) begin
      // Source select is stored as written; exclusivity is software's duty
      next_dout_cfg = pwdata[15:0] & `ADCRR_DIGITAL_OUTPUT_CONFIG_MASK;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      schedule <= `ADCRR_SCHEDULE_RESET;
      dout_cfg <= `ADCRR_DIGITAL_OUTPUT_CONFIG_RESET;
    end else begin
      schedule <= next_schedule;
      dout_cfg <= next_dout_cfg;
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always @* begin
    status_word = 32'h00000000;
    status_word[`ADCRR_PHASE_BIT] = phase_on;
    status_word[`ADCRR_BUSY_BIT] = (state == ST_CONV);
    status_word[`ADCRR_CH_LSB +: 3] = conv_channel;
  end

  // ----------------------------------------
  // APB read mux
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd_en) begin
      rdata <= 32'h00000000;
      if (hit_schedule) begin
        rdata <= {16'h0000, schedule};
      end else if (hit_dout) begin
        rdata <= {16'h0000, dout_cfg};
      end else if (hit_status) begin
        rdata <= status_word;
      end else if (slot_hit) begin
        rdata <= {{(32 - DATA_W){1'b0}}, result_slot[rd_slot]};
      end
    end
  end

  // ----------------------------------------
  // Phase enables, already in sampling order
  // ----------------------------------------
  wire [6:0] phase_sel;
  wire [6:0] order_en;
  wire pick_found;
  wire [2:0] pick_pos;
  wire phase_change;
  wire restart;

  assign phase_sel = gate_on ? schedule[`ADCRR_ON_LSB +: `ADCRR_SEL_W] :
                               schedule[`ADCRR_OFF_LSB +: `ADCRR_SEL_W];
  // Bit k of a phase field enables slot k+1; order position equals slot index
  assign order_en[0] = phase_sel[0];
  assign order_en[1] = phase_sel[1];
  assign order_en[2] = phase_sel[2];
  assign order_en[3] = phase_sel[3];
  assign order_en[4] = phase_sel[4];
  assign order_en[5] = phase_sel[5];
  assign order_en[6] = phase_sel[6];
  assign phase_change = (gate_on != phase_on);
  assign restart = phase_change || (state == ST_IDLE);

  adcrr_pick #(
    .N(`ADCRR_SEL_W)
  ) u_pick (
    .enables(order_en),
    .after_pos(cur_pos),
    .from_start(restart),
    .found(pick_found),
    .pos(pick_pos)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  wire wrap_found;
  wire [2:0] wrap_pos;
  wire [2:0] first_pos;
  integer s;

  adcrr_pick #(
    .N(`ADCRR_SEL_W)
  ) u_wrap (
    .enables(order_en),
    .after_pos(3'h0),
    .from_start(1'b1),
    .found(wrap_found),
    .pos(wrap_pos)
  );

  assign first_pos = pick_found ? pick_pos : wrap_pos;

  reg [1:0] next_state;
  reg [2:0] next_cur_pos;
  reg next_conv_start;
  reg [2:0] next_conv_channel;
  reg slot_we;

  // Idle re-arms every cycle, so a schedule write is picked up at once
  always @* begin
    next_state = state;
    next_cur_pos = cur_pos;
    next_conv_start = 1'b0;
    next_conv_channel = conv_channel;
    slot_we = 1'b0;
    case (state)
      ST_IDLE: begin
        if (wrap_found) begin
          next_cur_pos = wrap_pos;
          next_conv_channel = pos_to_channel(wrap_pos);
          next_conv_start = 1'b1;
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (phase_change) begin
          // Drop the result in flight; it belongs to the old phase
          next_state = ST_IDLE;
        end else if (conv_done) begin
          slot_we = 1'b1;
          if (wrap_found) begin
            next_cur_pos = first_pos;
            next_conv_channel = pos_to_channel(first_pos);
            next_conv_start = 1'b1;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Gate level is registered so each phase change is seen exactly once
  always @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
      cur_pos <= 3'h0;
      phase_on <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 3'h0;
    end else begin
      state <= next_state;
      cur_pos <= next_cur_pos;
      phase_on <= gate_on;
      conv_start <= next_conv_start;
      conv_channel <= next_conv_channel;
    end
  end

  // ----------------------------------------
  // Result slots
  // ----------------------------------------
  // Slots keep their value until the same channel converts again
  always @(posedge mclk) begin
    if (rst) begin
      for (s = 0; s < `ADCRR_NUM_SLOTS; s = s + 1) begin
        result_slot[s] <= {DATA_W{1'b0}};
      end
    end else if (slot_we) begin
      result_slot[channel_to_slot(conv_channel)] <= conv_data;
    end
  end

endmodule // adcrr_top

`default_nettype wire

// ===== rtl/adcrr_map.vh
// Register map and field layout of the converter schedule block.
// Assumes a 32-bit APB slave; each register takes one aligned word.
`ifndef ADCRR_MAP_VH
`define ADCRR_MAP_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADCRR_ADDR_SCHEDULE 8'h00
`define ADCRR_ADDR_DIGITAL_OUTPUT_CONFIG 8'h04
`define ADCRR_ADDR_STATUS 8'h08
`define ADCRR_ADDR_RESULT_BASE 8'h10
`define ADCRR_ADDR_RESULT_LAST 8'h28

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define ADCRR_OFF_LSB 0
`define ADCRR_ON_LSB 8
`define ADCRR_SEL_W 7
`define ADCRR_SCHEDULE_RESET 16'h0000
`define ADCRR_SCHEDULE_MASK 16'h7F7F
`define ADCRR_DIGITAL_OUTPUT_CONFIG_RESET 16'h1800
`define ADCRR_DIGITAL_OUTPUT_CONFIG_MASK 16'hFF7E
`define ADCRR_NUM_SLOTS 7
`define ADCRR_PHASE_BIT 0
`define ADCRR_BUSY_BIT 1
`define ADCRR_CH_LSB 4
`define ADCRR_WORD_LSB 2

`endif

// ===== rtl/adcrr_pick.v
// Picks the next enabled channel in sampling order after a given position.
// Assumes the enable vector is indexed by order position, not by input number.
`timescale 1ns/1ns
`default_nettype none

module adcrr_pick #(
  parameter N = 7
) (
  input wire [N-1:0] enables,
  input wire [2:0] after_pos,
  input wire from_start,
  output reg found,
  output reg [2:0] pos
);

  integer i;

  always @* begin
    found = 1'b0;
    pos = 3'h0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (enables[i] && (from_start || i > after_pos)) begin
        found = 1'b1;
        pos = i[2:0];
      end
    end
  end

endmodule // adcrr_pick

`default_nettype wire

// ===== tb/adcrr_props.sv
// Checker for the converter schedule block, bound to its top module.
// Assumes synchronous active-high reset and a zero-wait APB slave.
`timescale 1ns/1ns
`default_nettype none
module adcrr_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic gate_on,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  input wire logic [15:0] digital_output_config,
  input wire logic [15:0] adc_channel_schedule
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic acc = psel && penable;
  wire logic [6:0] en = gate_on ? adc_channel_schedule[14:8] : adc_channel_schedule[6:0];
  // Channel code to position in the sampling order
  function automatic [2:0] pos(input logic [2:0] c);
    pos = (c == 3'h6) ? 3'h6 : (c[0] ? 3'h3 + {1'b0, c[2:1]} : {1'b0, c[2:1]});
  endfunction
  a_reset_values: assert property ($fell(rst) |-> adc_channel_schedule == 16'h0000
    && digital_output_config == 16'h1800) else $error("bad reset value");
  a_idle_no_start: assert property (conv_start |-> $past(en) != 7'h00)
    else $error("start with nothing enabled");
  a_start_enabled: assert property (conv_start |-> (($past(en) >> pos(conv_channel)) & 7'h01) != 7'h00)
    else $error("started a disabled channel");
  a_channel_hold: assert property (!conv_start |-> $stable(conv_channel))
    else $error("channel moved without start");
  a_write_sched: assert property (acc && pwrite && paddr == 8'h00 |=>
    adc_channel_schedule == ($past(pwdata[15:0]) & 16'h7F7F)) else $error("schedule write lost");
  a_sched_hold: assert property (!(acc && pwrite && paddr == 8'h00) |=> $stable(adc_channel_schedule))
    else $error("schedule changed unasked");
  a_write_dout: assert property (acc && pwrite && paddr == 8'h04 |=>
    digital_output_config == ($past(pwdata[15:0]) & 16'hFF7E)) else $error("config write lost");
  a_dout_hold: assert property (!(acc && pwrite && paddr == 8'h04) |=> $stable(digital_output_config))
    else $error("config changed unasked");
  a_read_sched: assert property (acc && !pwrite && paddr == 8'h00 |->
    prdata == {16'h0000, adc_channel_schedule}) else $error("schedule read wrong");
  a_bus_ready: assert property (pready && !pslverr) else $error("bus not ready");
  cover property (conv_start && gate_on);
  cover property (conv_start && !gate_on);
  cover property (acc && pwrite);
endmodule // adcrr_props
bind adcrr_top adcrr_props adcrr_props_i (.*);
`default_nettype wire

// ===== tb/adcrr_top_test.sv
// Self-checking bench for the converter schedule block.
// Assumes the bench plays both APB master and converter.
`timescale 1ns/1ns
`default_nettype none
module adcrr_top_test;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gate_on = 1'b0, conv_done = 1'b0, conv_start, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0] conv_data = 10'h000;
  logic [2:0] conv_channel;
  logic [15:0] digital_output_config, adc_channel_schedule;
  int err_count = 0, comparisons = 0;
  // Row: {expected starts, gate level, schedule}
  logic [19:0] rows [4] = '{20'h5_0301, 20'hE_7C7F, 20'hB_7C00, 20'h4_0042};
  logic [2:0] ord [7] = '{3'h0, 3'h2, 3'h4, 3'h1, 3'h3, 3'h5, 3'h6};
  adcrr_top adcrr_top_i (.*);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task summarize;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_start;
    int k;
    k = 0;
    do begin @(posedge mclk); k++; end while (conv_start !== 1'b1 && k < 40);
    chk(conv_start, 32'h1);
  endtask
  task automatic run_row(input logic [19:0] w);
    int n, f;
    logic [9:0] d [7];
    n = 0;
    f = -1;
    apb(1'b1, 8'h00, 32'h0);
    // Gate change aborts any conversion left from the last row
    gate_on <= !w[16];
    repeat (3) begin @(posedge mclk); chk(conv_start, 32'h0); end
    gate_on <= w[16];
    apb(1'b1, 8'h00, {16'h0000, w[15:0]});
    for (int p = 0; p < 7; p++) if (w[p + (w[16] ? 8 : 0)]) begin
      wait_start;
      chk(conv_channel, ord[p]);
      if (f < 0) f = p;
      d[p] = 10'(w[7:0] + p);
      conv_data <= d[p];
      conv_done <= 1'b1;
      @(posedge mclk) conv_done <= 1'b0;
      n++;
    end
    wait_start;
    chk(conv_channel, ord[f]);
    chk(n, w[19:17]);
    for (int p = 0; p < 7; p++) if (w[p + (w[16] ? 8 : 0)]) begin
      apb(1'b0, 8'h10 + 8'(4 * p), 32'h0);
      chk(rd, {22'h0, d[p]});
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial forever #5 mclk = ~mclk;
  initial begin
    #300000;
    err_count++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1800);
    apb(1'b1, 8'h04, 32'hFFFFFFC0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'hFF40);
    apb(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h0);
    for (int r = 0; r < 4; r++) run_row(rows[r]);
    // Done on a gate edge is dropped; the empty on-phase starts nothing
    gate_on <= 1'b1;
    conv_data <= 10'h3FF;
    conv_done <= 1'b1;
    @(posedge mclk) conv_done <= 1'b0;
    repeat (3) begin @(posedge mclk); chk(conv_start, 32'h0); end
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h43);
    gate_on <= 1'b0;
    wait_start;
    chk(conv_channel, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h22);
    // Mid-run reset must restore both registers
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1800);
    summarize;
  end
endmodule // adcrr_top_test
`default_nettype wire
